/* File: verilog/adc_port_consts.svh */
// offsets, fields, codes and reset values of the converter back end and serial port
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

`define ADDR_W              13
`define REG_PORT_CFG        13'h0000
`define REG_MODE_CFG        13'h0008
`define REG_TEST_CTRL       13'h000D
`define REG_OUT_MODE        13'h0014
`define REG_TRANSFER        13'h00FF
`define SHADOW_FIRST        13'h0008
`define SHADOW_LAST         13'h0018

`define PORT_CFG_RESET      8'h00
`define MODE_CFG_RESET      8'h00
`define TEST_CTRL_RESET     8'h00
`define OUT_MODE_RESET      8'h00

`define PORT_LSB_FIRST_BIT  6
`define TRANSFER_BIT        0
`define PIN_FN_HI           6
`define PIN_FN_LO           5
`define PIN_FN_OFF          2'h0
`define PIN_FN_POWERDOWN    2'h1
`define PIN_FN_TRISTATE     2'h2
`define POWER_HI            1
`define POWER_LO            0
`define POWER_NORMAL        2'h0
`define TEST_HI             3
`define TEST_LO             0
`define PN_LONG_RESET_BIT   4
`define PN_SHORT_RESET_BIT  5
`define FMT_HI              1
`define FMT_LO              0
`define FMT_OFFSET          2'h0
`define FMT_TWOS            2'h1
`define FMT_GRAY            2'h2

`define TEST_OFF            4'h0
`define TEST_MIDSCALE       4'h1
`define TEST_POS_FULL       4'h2
`define TEST_NEG_FULL       4'h3
`define TEST_CHECKER        4'h4
`define TEST_PN_LONG        4'h5
`define TEST_PN_SHORT       4'h6
`define TEST_ONE_ZERO       4'h7

`define CODE_MIDSCALE       16'h8000
`define CODE_POS_FULL       16'hFFFF
`define CODE_NEG_FULL       16'h0000
`define CODE_CHECKER_A      16'h5555
`define CODE_CHECKER_B      16'hAAAA
`define PN_LONG_SEED        23'h7FFFFF
`define PN_SHORT_SEED       9'h1FF

`define INSTR_LAST_BIT      4'hF
`define BYTE_LAST_BIT       4'h7
`define LEN_STREAM          2'h3
`define PIPE_STAGES         8

`endif

/* File: verilog/adc_port_pkg.sv */
// types shared by the converter back end and its serial port
package adc_port_pkg;

	typedef enum logic [0:0] {
		PHASE_INSTR,
		PHASE_DATA
	} serial_phase_type;

endpackage : adc_port_pkg

/* File: verilog/sample_delay_line.sv */
// fixed-depth delay line holding formatted samples in flops
`timescale 1ns/1ps
`include "adc_port_consts.svh"

module sample_delay_line #(
	parameter int WIDTH = 17,
	parameter int DEPTH = `PIPE_STAGES
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// data
	input  wire logic [WIDTH-1:0] din_i,
	output logic      [WIDTH-1:0] dout_o
);

	logic [WIDTH-1:0] stage [DEPTH];

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= '0;
			end
		end else begin
			stage[0] <= din_i;
			for (int i = 1; i < DEPTH; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign dout_o = stage[DEPTH-1];

endmodule : sample_delay_line

/* File: verilog/adc_output_and_config_port.sv */
// converter output back end with its three-wire serial configuration port
`timescale 1ns/1ps
`include "adc_port_consts.svh"

module adc_output_and_config_port #(
	parameter int SAMPLE_W = 16
) (
	// converter clock and reset
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	// samples from the converter core
	input  wire logic [SAMPLE_W-1:0] sample_i,
	input  wire logic                sample_over_range_i,
	// serial port pins
	input  wire logic                serial_clock_format_strap_i,
	input  wire logic                chip_select_n_i,
	input  wire logic                serial_data_powerdown_strap_i,
	output logic                     serial_data_powerdown_strap_o,
	output logic                     serial_data_powerdown_strap_oe_o,
	// mode pin
	input  wire logic                output_tristate_control_i,
	// data outputs
	output logic      [SAMPLE_W-1:0] data_o,
	output logic                     out_of_range_o,
	output logic                     data_oe_o,
	output logic                     data_clock_out_o,
	output logic                     data_clock_out_oe_o
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7-i];
		end
		return r;
	endfunction : rev8

	function automatic logic [7:0] reg_value(
		input logic [`ADDR_W-1:0] a,
		input logic [7:0]         port_v,
		input logic [7:0]         mode_v,
		input logic [7:0]         test_v,
		input logic [7:0]         out_v
	);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`REG_PORT_CFG:  v = port_v;
			`REG_MODE_CFG:  v = mode_v;
			`REG_TEST_CTRL: v = test_v;
			`REG_OUT_MODE:  v = out_v;
			default:        v = 8'h00;
		endcase
		return v;
	endfunction : reg_value

	function automatic logic [SAMPLE_W-1:0] format_code(
		input logic [SAMPLE_W-1:0] code,
		input logic [1:0]          fmt
	);
		logic [SAMPLE_W-1:0] f;
		f = code;
		case (fmt)
			`FMT_TWOS: f = {~code[SAMPLE_W-1], code[SAMPLE_W-2:0]};
			`FMT_GRAY: f = code ^ (code >> 1);
			default:   f = code;
		endcase
		return f;
	endfunction : format_code

	////////////////////////////////////////////////////////////////////////////////
	// serial clock domain: reset and framing

	logic                          sreset_meta;
	logic                          sreset_n;
	adc_port_pkg::serial_phase_type phase;
	logic [15:0]                   rx_shift;
	logic [3:0]                    bit_cnt;
	logic [1:0]                    byte_cnt;
	logic                          rw;
	logic [1:0]                    len;
	logic [`ADDR_W-1:0]            addr;
	logic [7:0]                    tx_byte;
	logic                          spi_used;
	logic [7:0]                    port_cfg;
	logic [7:0]                    mode_sh;
	logic [7:0]                    test_sh;
	logic [7:0]                    out_sh;
	logic [7:0]                    mode_act;
	logic [7:0]                    test_act;
	logic [7:0]                    out_act;
	logic                          xfer_toggle;
	logic                          sdio_out;
	logic                          sdio_drive;

	logic                          shift_en;
	logic                          lsb_first;
	logic [15:0]                   rx_next;
	logic [15:0]                   instr;
	logic [7:0]                    wr_byte;
	logic                          instr_done;
	logic                          byte_done;
	logic                          frame_end;
	logic                          wr_en;
	logic [`ADDR_W-1:0]            next_addr;

	always_ff @(posedge serial_clock_format_strap_i) begin
		sreset_meta <= rstn_i;
		sreset_n    <= sreset_meta;
	end

	assign shift_en   = !chip_select_n_i;
	assign lsb_first  = port_cfg[`PORT_LSB_FIRST_BIT];
	assign rx_next    = {rx_shift[14:0], serial_data_powerdown_strap_i};
	assign instr      = lsb_first ? {rev8(rx_next[7:0]), rev8(rx_next[15:8])}
	                              : rx_next;
	assign wr_byte    = lsb_first ? rev8(rx_next[7:0]) : rx_next[7:0];
	assign instr_done = shift_en && phase == adc_port_pkg::PHASE_INSTR
	                    && bit_cnt == `INSTR_LAST_BIT;
	assign byte_done  = shift_en && phase == adc_port_pkg::PHASE_DATA
	                    && bit_cnt == `BYTE_LAST_BIT;
	assign frame_end  = byte_done && len != `LEN_STREAM && byte_cnt == len;
	assign wr_en      = byte_done && !rw;
	assign next_addr  = lsb_first ? addr + `ADDR_W'(1) : addr - `ADDR_W'(1);

	always_ff @(posedge serial_clock_format_strap_i) begin
		if (!sreset_n) begin
			phase    <= adc_port_pkg::PHASE_INSTR;
			rx_shift <= 16'h0000;
			bit_cnt  <= 4'h0;
			byte_cnt <= 2'h0;
			rw       <= 1'b0;
			len      <= 2'h0;
			addr     <= '0;
			tx_byte  <= 8'h00;
		end else if (shift_en) begin
			rx_shift <= rx_next;
			case (phase)
				adc_port_pkg::PHASE_INSTR: begin
					if (instr_done) begin
						rw       <= instr[15];
						len      <= instr[14:13];
						addr     <= instr[`ADDR_W-1:0];
						tx_byte  <= reg_value(instr[`ADDR_W-1:0], port_cfg,
						                      mode_sh, test_sh, out_sh);
						byte_cnt <= 2'h0;
						bit_cnt  <= 4'h0;
						phase    <= adc_port_pkg::PHASE_DATA;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				adc_port_pkg::PHASE_DATA: begin
					if (byte_done) begin
						bit_cnt  <= 4'h0;
						addr     <= next_addr;
						tx_byte  <= reg_value(next_addr, port_cfg, mode_sh, test_sh, out_sh);
						byte_cnt <= (byte_cnt == `LEN_STREAM) ? byte_cnt : byte_cnt + 2'h1;
						if (frame_end) begin
							phase <= adc_port_pkg::PHASE_INSTR;
						end
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				default: begin
					phase <= adc_port_pkg::PHASE_INSTR;
				end
			endcase
		end else if (phase == adc_port_pkg::PHASE_DATA && len == `LEN_STREAM) begin
			// select raised in streaming ends the frame
			phase   <= adc_port_pkg::PHASE_INSTR;
			bit_cnt <= 4'h0;
		end
		// fixed-length frames simply hold while select is high
	end

	always_ff @(posedge serial_clock_format_strap_i) begin
		if (!sreset_n) begin
			spi_used <= 1'b0;
		end else if (instr_done) begin
			spi_used <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register file and transfer

	always_ff @(posedge serial_clock_format_strap_i) begin
		if (!sreset_n) begin
			port_cfg <= `PORT_CFG_RESET;
			mode_sh  <= `MODE_CFG_RESET;
			test_sh  <= `TEST_CTRL_RESET;
			out_sh   <= `OUT_MODE_RESET;
		end else if (wr_en) begin
			case (addr)
				`REG_PORT_CFG:  port_cfg <= wr_byte;
				`REG_MODE_CFG:  mode_sh  <= wr_byte;
				`REG_TEST_CTRL: test_sh  <= wr_byte;
				`REG_OUT_MODE:  out_sh   <= wr_byte;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge serial_clock_format_strap_i) begin
		if (!sreset_n) begin
			mode_act    <= `MODE_CFG_RESET;
			test_act    <= `TEST_CTRL_RESET;
			out_act     <= `OUT_MODE_RESET;
			xfer_toggle <= 1'b0;
		end else if (wr_en && addr == `REG_TRANSFER && wr_byte[`TRANSFER_BIT]) begin
			mode_act    <= mode_sh;
			test_act    <= test_sh;
			out_act     <= out_sh;
			xfer_toggle <= !xfer_toggle;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// readback driver on the falling serial edge

	always_ff @(negedge serial_clock_format_strap_i) begin
		if (!sreset_n) begin
			sdio_out   <= 1'b0;
			sdio_drive <= 1'b0;
		end else begin
			sdio_out   <= lsb_first ? tx_byte[bit_cnt[2:0]]
			                        : tx_byte[3'h7 - bit_cnt[2:0]];
			sdio_drive <= shift_en && phase == adc_port_pkg::PHASE_DATA && rw;
		end
	end

	assign serial_data_powerdown_strap_o    = sdio_out;
	// select high releases the pin at once, even with the serial clock stopped
	assign serial_data_powerdown_strap_oe_o = sdio_drive && !chip_select_n_i;

	////////////////////////////////////////////////////////////////////////////////
	// converter clock domain: synchronisers and configuration capture

	logic [4:0] sync_meta;
	logic [4:0] sync_q;
	logic       xfer_seen;
	logic [7:0] cfg_mode;
	logic [7:0] cfg_test;
	logic [7:0] cfg_out;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sync_meta <= 5'h00;
			sync_q    <= 5'h00;
		end else begin
			sync_meta <= {xfer_toggle, spi_used, output_tristate_control_i,
			              serial_data_powerdown_strap_i, serial_clock_format_strap_i};
			sync_q    <= sync_meta;
		end
	end

	// configuration words are stable long before the toggle lands here
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			xfer_seen <= 1'b0;
			cfg_mode  <= `MODE_CFG_RESET;
			cfg_test  <= `TEST_CTRL_RESET;
			cfg_out   <= `OUT_MODE_RESET;
		end else begin
			xfer_seen <= sync_q[4];
			if (sync_q[4] != xfer_seen) begin
				cfg_mode <= mode_act;
				cfg_test <= test_act;
				cfg_out  <= out_act;
			end
		end
	end

	logic       pin_mode;
	logic       mode_pin;
	logic [1:0] pin_fn;
	logic [1:0] fmt;
	logic       power_down;
	logic       tristate;
	logic [3:0] test_mode;

	assign pin_mode   = !sync_q[3];
	assign mode_pin   = sync_q[2];
	assign pin_fn     = cfg_mode[`PIN_FN_HI:`PIN_FN_LO];
	assign fmt        = pin_mode ? (sync_q[0] ? `FMT_TWOS : `FMT_OFFSET)
	                             : cfg_out[`FMT_HI:`FMT_LO];
	assign power_down = pin_mode ? sync_q[1]
	                  : (cfg_mode[`POWER_HI:`POWER_LO] != `POWER_NORMAL)
	                    || (pin_fn == `PIN_FN_POWERDOWN && mode_pin);
	assign tristate   = power_down
	                  || (!pin_mode && pin_fn == `PIN_FN_TRISTATE && mode_pin);
	assign test_mode  = pin_mode ? `TEST_OFF : cfg_test[`TEST_HI:`TEST_LO];

	////////////////////////////////////////////////////////////////////////////////
	// test pattern generators

	logic [22:0] pn_long;
	logic [8:0]  pn_short;
	logic        alt;

	always_ff @(posedge clk_i) begin
		if (!rstn_i || cfg_test[`PN_LONG_RESET_BIT]) begin
			pn_long <= `PN_LONG_SEED;
		end else begin
			pn_long <= {pn_long[21:0], pn_long[22] ^ pn_long[17]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i || cfg_test[`PN_SHORT_RESET_BIT]) begin
			pn_short <= `PN_SHORT_SEED;
		end else begin
			pn_short <= {pn_short[7:0], pn_short[8] ^ pn_short[4]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			alt <= 1'b0;
		end else begin
			alt <= !alt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// source select, formatting and pipeline

	logic [SAMPLE_W-1:0] raw_code;
	logic                raw_or;

	always_comb begin
		raw_code = sample_i;
		raw_or   = sample_over_range_i;
		if (test_mode != `TEST_OFF) begin
			raw_or = 1'b0;
		end
		case (test_mode)
			`TEST_OFF:      raw_code = sample_i;
			`TEST_MIDSCALE: raw_code = `CODE_MIDSCALE;
			`TEST_POS_FULL: raw_code = `CODE_POS_FULL;
			`TEST_NEG_FULL: raw_code = `CODE_NEG_FULL;
			`TEST_CHECKER:  raw_code = alt ? `CODE_CHECKER_B : `CODE_CHECKER_A;
			`TEST_PN_LONG:  raw_code = pn_long[22:7];
			`TEST_PN_SHORT: raw_code = {pn_short, pn_short[8:2]};
			`TEST_ONE_ZERO: raw_code = alt ? `CODE_POS_FULL : `CODE_NEG_FULL;
			default:        raw_code = sample_i;
		endcase
	end

	logic [SAMPLE_W:0] pipe_out;

	sample_delay_line #(
		.WIDTH (SAMPLE_W + 1),
		.DEPTH (`PIPE_STAGES)
	) u_delay (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.din_i  ({raw_or, format_code(raw_code, fmt)}),
		.dout_o (pipe_out)
	);

	assign data_o         = pipe_out[SAMPLE_W-1:0];
	assign out_of_range_o = pipe_out[SAMPLE_W];

	////////////////////////////////////////////////////////////////////////////////
	// output enables and data clock

	logic drive_en;
	logic data_clock_out;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			drive_en <= 1'b0;
		end else begin
			drive_en <= !tristate;
		end
	end

	// toggles mid-word so both of its edges fall inside a data eye
	always_ff @(negedge clk_i) begin
		if (!rstn_i || power_down) begin
			data_clock_out <= 1'b0;
		end else begin
			data_clock_out <= !data_clock_out;
		end
	end

	assign data_oe_o           = drive_en;
	assign data_clock_out_o    = data_clock_out;
	assign data_clock_out_oe_o = drive_en;

endmodule : adc_output_and_config_port

/* File: tb/adc_port_properties.sv */
// concurrent checks on the converter back end and serial port pins
`timescale 1ns/1ps

module adc_port_properties #(
	parameter int SAMPLE_W = 16
) (
	// clocks and reset
	input wire logic                clk_i,
	input wire logic                rstn_i,
	input wire logic                serial_clock_format_strap_i,
	// inputs
	input wire logic [SAMPLE_W-1:0] sample_i,
	input wire logic                sample_over_range_i,
	input wire logic                chip_select_n_i,
	input wire logic                serial_data_powerdown_strap_i,
	input wire logic                output_tristate_control_i,
	// outputs
	input wire logic                serial_data_powerdown_strap_o,
	input wire logic                serial_data_powerdown_strap_oe_o,
	input wire logic [SAMPLE_W-1:0] data_o,
	input wire logic                out_of_range_o,
	input wire logic                data_oe_o,
	input wire logic                data_clock_out_o,
	input wire logic                data_clock_out_oe_o
);
	////////////////////////////////////////
	property p_or_source;
		@(posedge clk_i) disable iff (!rstn_i)
		out_of_range_o |-> $past(sample_over_range_i, 8);
	endproperty
	a_or_source: assert property (p_or_source)
		else $error("range flag without cause");
	property p_or_code;
		@(posedge clk_i) disable iff (!rstn_i)
		out_of_range_o |-> (data_o == 16'hFFFF || data_o == 16'h7FFF
			|| data_o == 16'h0000 || data_o == 16'h8000);
	endproperty
	a_or_code: assert property (p_or_code)
		else $error("range flag with inner code");
	property p_rose_or_code;
		@(posedge clk_i) disable iff (!rstn_i)
		$rose(out_of_range_o) |-> (data_o == $past(sample_i, 8)
			|| data_o == ($past(sample_i, 8) ^ 16'h8000));
	endproperty
	a_rose_or_code: assert property (p_rose_or_code)
		else $error("word not eight cycles late");
	property p_dco_pair;
		@(posedge clk_i) disable iff (!rstn_i)
		data_clock_out_oe_o == data_oe_o;
	endproperty
	a_dco_pair: assert property (p_dco_pair)
		else $error("clock and data enables differ");
	property p_dco_toggle;
		@(posedge clk_i) disable iff (!rstn_i)
		data_oe_o |-> $past(data_clock_out_o) != $past(data_clock_out_o, 2);
	endproperty
	a_dco_toggle: assert property (p_dco_toggle)
		else $error("data clock not toggling");
	property p_sel_float;
		@(posedge clk_i) disable iff (!rstn_i)
		chip_select_n_i |-> !serial_data_powerdown_strap_oe_o;
	endproperty
	a_sel_float: assert property (p_sel_float)
		else $error("data pin driven while deselected");
	property p_read_turn;
		@(posedge serial_clock_format_strap_i) disable iff (!rstn_i)
		$rose(serial_data_powerdown_strap_oe_o) |-> !$past(chip_select_n_i, 16);
	endproperty
	a_read_turn: assert property (p_read_turn)
		else $error("turnaround before instruction end");
	property p_read_byte;
		@(posedge serial_clock_format_strap_i) disable iff (!rstn_i)
		$rose(serial_data_powerdown_strap_oe_o) |-> serial_data_powerdown_strap_oe_o [*8];
	endproperty
	a_read_byte: assert property (p_read_byte)
		else $error("read byte cut short");
endmodule : adc_port_properties

/* File: tb/serial_master_model.sv */
// serial configuration master for the three-wire port, also holding the straps
`timescale 1ns/1ps

module serial_master_model (
	// serial pins
	output logic     sclk_o,
	output logic     cs_n_o,
	output logic     sdio_o,
	// device side of the data pin
	input wire logic dev_d_i,
	input wire logic dev_oe_i,
	// resolved data pin
	output logic     sdio_w_o
);
	logic fmt_strap;
	logic pd_strap;
	logic lsb;

	assign sdio_w_o = dev_oe_i ? dev_d_i : sdio_o;

	initial begin
		fmt_strap = 1'b0;
		pd_strap = 1'b0;
		lsb = 1'b0;
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdio_o = 1'b0;
	end
	////////////////////////////////////////
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			#6 sclk_o = 1'b1;
			#6 sclk_o = 1'b0;
		end
	endtask : pulses

	task automatic set_straps(input logic f, input logic p);
		fmt_strap = f;
		pd_strap = p;
		sclk_o = f;
		sdio_o = p;
	endtask : set_straps

	task automatic shift_bit(input logic b, output logic r);
		sdio_o = b;
		#6 sclk_o = 1'b1;
		r = sdio_w_o;
		#6 sclk_o = 1'b0;
	endtask : shift_bit

	task automatic frame(input logic rw, input logic [1:0] len, input logic [12:0] a,
			input int n, input logic pause, input logic [23:0] wd, output logic [23:0] rd);
		logic [15:0] ins;
		logic [7:0]  by;
		logic        r;
		rd = 24'h000000;
		ins = {rw, len, a};
		sclk_o = 1'b0;
		#6 cs_n_o = 1'b0;
		for (int i = 0; i < 16; i++) shift_bit(ins[lsb ? i : 15 - i], r);
		for (int k = 0; k < n; k++) begin
			if (pause && k > 0) begin
				#6 cs_n_o = 1'b1;
				#30 cs_n_o = 1'b0;
			end
			by = wd[23 - 8 * k -: 8];
			for (int i = 0; i < 8; i++) begin
				shift_bit(rw ? ~sdio_o : by[lsb ? i : 7 - i], r);
				rd[23 - 8 * k - (lsb ? 7 - i : i)] = r;
			end
		end
		#6 cs_n_o = 1'b1;
		// a stream only ends at a serial edge seen with select high
		if (len == 2'h3) pulses(1);
		set_straps(fmt_strap, pd_strap);
	endtask : frame
endmodule : serial_master_model

/* File: tb/adc_output_and_config_port_tb_top.sv */
// bench driving samples, straps and register frames into the converter back end
`timescale 1ns/1ps
`include "adc_port_consts.svh"

module adc_output_and_config_port_tb_top;
	logic        clk_i;
	logic        rstn_i;
	logic [15:0] sample_i;
	logic        sample_over_range_i;
	logic        output_tristate_control_i;
	logic        sclk;
	logic        cs_n;
	logic        sdio_m;
	logic        sdio_w;
	logic        sdio_d;
	logic        sdio_oe;
	logic [15:0] data_o;
	logic        out_of_range_o;
	logic        data_oe_o;
	logic        data_clock_out;
	logic        dco_oe;
	logic [16:0] hist [0:8];
	logic [15:0] acc;
	logic [15:0] prev;
	logic [15:0] tcode;
	logic [23:0] rbuf;
	int          cyc;
	int          failures;
	int          cmp_count;

	adc_output_and_config_port #(.SAMPLE_W(16)) u_adc_output_and_config_port (
		.clk_i(clk_i), .rstn_i(rstn_i), .sample_i(sample_i),
		.sample_over_range_i(sample_over_range_i), .serial_clock_format_strap_i(sclk),
		.chip_select_n_i(cs_n), .serial_data_powerdown_strap_i(sdio_w),
		.serial_data_powerdown_strap_o(sdio_d), .serial_data_powerdown_strap_oe_o(sdio_oe),
		.output_tristate_control_i(output_tristate_control_i), .data_o(data_o),
		.out_of_range_o(out_of_range_o), .data_oe_o(data_oe_o),
		.data_clock_out_o(data_clock_out), .data_clock_out_oe_o(dco_oe));

	serial_master_model u_serial_master_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(sdio_m),
		.dev_d_i(sdio_d), .dev_oe_i(sdio_oe), .sdio_w_o(sdio_w));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		#1;
		acc = acc + 16'h1357;
		cyc++;
		for (int i = 8; i > 0; i--) hist[i] = hist[i - 1];
		hist[0] = (cyc % 5 == 0) ? {1'b1, 16'hFFFF} : {1'b0, acc};
		{sample_over_range_i, sample_i} = hist[0];
	end
	////////////////////////////////////////
	task automatic complete_run;
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		cmp_count++;
		if (exp !== got) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_data(input logic twos);
		repeat (12) @(posedge clk_i);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			#2 chk("data", {hist[8][16], hist[8][15:0] ^ {twos, 15'h0000}},
				{out_of_range_o, data_o});
		end
	endtask : chk_data

	task automatic chk_oe(input logic e);
		repeat (5) @(posedge clk_i);
		#2 chk("enable", {15'h0000, e, e}, {15'h0000, data_oe_o, dco_oe});
	endtask : chk_oe

	task automatic wr(input logic [12:0] a, input logic [7:0] v);
		u_serial_master_model.frame(1'b0, 2'h0, a, 1, 1'b0, {v, 16'h0000}, rbuf);
	endtask : wr

	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		u_serial_master_model.frame(1'b1, 2'h0, a, 1, 1'b0, 24'h000000, rbuf);
		chk("register", {9'h000, e}, {9'h000, rbuf[23:16]});
	endtask : rd

	task automatic commit(input logic [12:0] a, input logic [7:0] v);
		wr(a, v);
		wr(`REG_TRANSFER, 8'h01);
		repeat (14) @(posedge clk_i);
		#2;
	endtask : commit
	////////////////////////////////////////
	initial begin
		#200000;
		failures++;
		complete_run();
	end

	initial begin
		sample_i = 16'h0000;
		sample_over_range_i = 1'b0;
		output_tristate_control_i = 1'b0;
		rstn_i = 1'b0;
		acc = 16'h0000;
		cyc = 0;
		failures = 0;
		cmp_count = 0;
		fork
			repeat (6) @(posedge clk_i);
			u_serial_master_model.pulses(6);
		join
		#1 rstn_i = 1'b1;
		// serial side leaves reset only on its own clock edges
		u_serial_master_model.pulses(3);
		chk_data(1'b0);
		chk_oe(1'b1);
		u_serial_master_model.set_straps(1'b1, 1'b0);
		chk_data(1'b1);
		u_serial_master_model.set_straps(1'b0, 1'b1);
		chk_oe(1'b0);
		u_serial_master_model.set_straps(1'b0, 1'b0);
		chk_oe(1'b1);
		rd(`REG_PORT_CFG, `PORT_CFG_RESET);
		rd(`REG_MODE_CFG, `MODE_CFG_RESET);
		rd(`REG_TEST_CTRL, `TEST_CTRL_RESET);
		rd(`REG_OUT_MODE, `OUT_MODE_RESET);
		wr(`REG_OUT_MODE, 8'h01);
		chk_data(1'b0);
		commit(`REG_TRANSFER, 8'h01);
		chk_data(1'b1);
		rd(`REG_TRANSFER, 8'h00);
		rd(`REG_OUT_MODE, 8'h01);
		rd(13'h0013, 8'h00);
		commit(`REG_OUT_MODE, 8'h00);
		output_tristate_control_i = 1'b1;
		chk_oe(1'b1);
		commit(`REG_MODE_CFG, 8'h40);
		chk_oe(1'b0);
		output_tristate_control_i = 1'b0;
		chk_oe(1'b1);
		commit(`REG_MODE_CFG, 8'h01);
		chk_oe(1'b0);
		commit(`REG_MODE_CFG, 8'h00);
		for (int i = 1; i < 8; i++) begin
			commit(`REG_TEST_CTRL, 8'(i));
			tcode = (i == 1) ? `CODE_MIDSCALE : (i == 2) ? `CODE_POS_FULL : `CODE_NEG_FULL;
			prev = data_o;
			@(posedge clk_i);
			#2;
			if (i < 4)
				chk("pattern", {1'b0, tcode}, {out_of_range_o, data_o});
			else if (i == 4 || i == 7)
				chk("alternate", {1'b0, ~prev}, {out_of_range_o, data_o});
			else
				chk("sequence", 17'h00001, {16'h0000, prev !== data_o});
		end
		for (int j = 0; j < 2; j++) begin
			commit(`REG_TEST_CTRL, (j == 0) ? 8'h15 : 8'h26);
			prev = data_o;
			@(posedge clk_i);
			#2 chk("held", {1'b0, prev}, {1'b0, data_o});
		end
		u_serial_master_model.frame(1'b0, 2'h1, `REG_TEST_CTRL, 2, 1'b1, 24'h030000, rbuf);
		commit(`REG_TRANSFER, 8'h01);
		chk("paused", {1'b0, `CODE_NEG_FULL}, {out_of_range_o, data_o});
		u_serial_master_model.frame(1'b1, 2'h3, `REG_TEST_CTRL, 3, 1'b0, 24'h000000, rbuf);
		chk("stream", {1'b0, 16'h0300}, {1'b0, rbuf[23:8]});
		wr(`REG_PORT_CFG, 8'h40);
		u_serial_master_model.lsb = 1'b1;
		rd(`REG_TEST_CTRL, 8'h03);
		wr(`REG_PORT_CFG, 8'h00);
		u_serial_master_model.lsb = 1'b0;
		rd(`REG_PORT_CFG, 8'h00);
		commit(`REG_TEST_CTRL, 8'h00);
		chk_data(1'b0);
		complete_run();
	end
endmodule : adc_output_and_config_port_tb_top

bind adc_output_and_config_port adc_port_properties #(.SAMPLE_W(SAMPLE_W)) u_adc_port_properties (
	.clk_i(clk_i), .rstn_i(rstn_i), .serial_clock_format_strap_i(serial_clock_format_strap_i),
	.sample_i(sample_i), .sample_over_range_i(sample_over_range_i),
	.chip_select_n_i(chip_select_n_i),
	.serial_data_powerdown_strap_i(serial_data_powerdown_strap_i),
	.output_tristate_control_i(output_tristate_control_i),
	.serial_data_powerdown_strap_o(serial_data_powerdown_strap_o),
	.serial_data_powerdown_strap_oe_o(serial_data_powerdown_strap_oe_o),
	.data_o(data_o), .out_of_range_o(out_of_range_o), .data_oe_o(data_oe_o),
	.data_clock_out_o(data_clock_out_o), .data_clock_out_oe_o(data_clock_out_oe_o));
